// [port_pin_mux_strap_capture.sv]
// pin steering for parallel data pins and serial pin groups, with straps
`timescale 1ns/1ps

module port_pin_mux_strap_capture
    import pin_mux_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire pin_mode_e mode,
    input wire logic [PD_WIDTH-1:0] pp_data_out,
    input wire logic pp_data_oe,
    output logic [PD_WIDTH-1:0] pp_data_in,
    input wire logic floppy_motor_on_a_n,
    input wire logic floppy_select_a_n,
    output logic ext_read_data_n,
    output logic ext_disk_change_n,
    input wire logic [PD_WIDTH-1:0] pd_pin_in,
    output logic [PD_WIDTH-1:0] pd_pin_out,
    output logic [PD_WIDTH-1:0] pd_pin_oe,
    input wire modem_in_s modem_a_in,
    input wire modem_in_s modem_b_in,
    input wire uart_line_s uart_a_ctl,
    input wire uart_line_s uart_b_ctl,
    input wire uart_line_s line_a_in,
    input wire uart_line_s line_b_in,
    output uart_line_s line_a_out,
    output uart_line_s line_a_oe,
    output uart_line_s line_b_out,
    output uart_line_s line_b_oe,
    output logic serial_in_a,
    output logic serial_in_b,
    output logic [7:0] hs_status_a,
    output logic [7:0] hs_status_b,
    input wire logic sw_wr_24,
    input wire logic [7:0] sw_data_24,
    input wire logic sw_wr_26,
    input wire logic [7:0] sw_data_26,
    output strap_s straps,
    output logic [7:0] cfg_port_addr
);

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [SYNC_WIDTH-1:0] async_in;
    logic [SYNC_WIDTH-1:0] meta_reg;
    logic [SYNC_WIDTH-1:0] sync_reg;
    logic [PD_WIDTH-1:0] pd_s;
    modem_in_s modem_a_s;
    modem_in_s modem_b_s;
    uart_line_s line_a_s;
    uart_line_s line_b_s;

    assign async_in = {pd_pin_in, modem_a_in, modem_b_in, line_a_in, line_b_in};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_WIDTH; gi++) begin : g_sync
            // no reset: straps are sampled through these while reset is held
            always_ff @(posedge clk_sys) begin
                meta_reg[gi] <= async_in[gi];
                sync_reg[gi] <= meta_reg[gi];
            end
        end
    endgenerate

    assign {pd_s, modem_a_s, modem_b_s, line_a_s, line_b_s} = sync_reg;

    // ----------------------------------------------------------------
    // parallel data pin steering
    // ----------------------------------------------------------------
    logic [PD_WIDTH-1:0] pd_out_reg, pd_out_next;
    logic [PD_WIDTH-1:0] pd_oe_reg, pd_oe_next;
    logic [PD_WIDTH-1:0] pp_in_reg, pp_in_next;
    logic read_reg, read_next;
    logic change_reg, change_next;

    always_comb begin
        pd_out_next = '0;
        pd_oe_next = '0;
        pp_in_next = pp_in_reg;
        read_next = 1'b1;
        change_next = 1'b1;
        if (!rst_n) begin
            pp_in_next = '0;
        end else begin
            case (mode)
                MODE_PRINTER: begin
                    pd_out_next = pp_data_out;
                    pd_oe_next = {PD_WIDTH{pp_data_oe}};
                    pp_in_next = pd_s;
                end
                MODE_EXT_SINGLE: begin
                    read_next = pd_s[PD_IDX_READ];
                    change_next = pd_s[PD_IDX_CHANGE];
                    pd_oe_next = '0;
                end
                MODE_EXT_DUAL: begin
                    read_next = pd_s[PD_IDX_READ];
                    change_next = pd_s[PD_IDX_CHANGE];
                    pd_oe_next[PD_IDX_FLOAT] = 1'b0;
                    pd_oe_next[PD_IDX_MOTOR] = ~floppy_motor_on_a_n;
                    pd_oe_next[PD_IDX_SELECT] = ~floppy_select_a_n;
                end
                default: begin
                    pd_oe_next = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        pd_out_reg <= pd_out_next;
        pd_oe_reg <= pd_oe_next;
        pp_in_reg <= pp_in_next;
        read_reg <= read_next;
        change_reg <= change_next;
    end

    assign pd_pin_out = pd_out_reg;
    assign pd_pin_oe = pd_oe_reg;
    assign pp_data_in = pp_in_reg;
    assign ext_read_data_n = read_reg;
    assign ext_disk_change_n = change_reg;

    // ----------------------------------------------------------------
    // serial pin groups
    // ----------------------------------------------------------------
    uart_line_s a_out_reg, a_out_next, b_out_reg, b_out_next;
    logic line_oe_reg, line_oe_next;
    logic [7:0] hs_a_reg, hs_a_next, hs_b_reg, hs_b_next;
    logic sin_a_reg, sin_a_next, sin_b_reg, sin_b_next;

    function automatic logic [7:0] hs_bits(input modem_in_s m);
        logic [7:0] v;
        v = HS_RESET;
        v[HS_CTS_BIT] = ~m.cts_n;
        v[HS_DSR_BIT] = ~m.dsr_n;
        v[HS_RI_BIT] = ~m.ri_n;
        v[HS_DCD_BIT] = ~m.dcd_n;
        return v;
    endfunction

    always_comb begin
        if (!rst_n) begin
            a_out_next = '1;
            b_out_next = '1;
            line_oe_next = 1'b0;
            hs_a_next = HS_RESET;
            hs_b_next = HS_RESET;
            sin_a_next = 1'b1;
            sin_b_next = 1'b1;
        end else begin
            a_out_next = uart_a_ctl;
            b_out_next = uart_b_ctl;
            line_oe_next = 1'b1;
            hs_a_next = hs_bits(modem_a_s);
            hs_b_next = hs_bits(modem_b_s);
            sin_a_next = modem_a_s.sin;
            sin_b_next = modem_b_s.sin;
        end
    end

    always_ff @(posedge clk_sys) begin
        a_out_reg <= a_out_next;
        b_out_reg <= b_out_next;
        line_oe_reg <= line_oe_next;
        hs_a_reg <= hs_a_next;
        hs_b_reg <= hs_b_next;
        sin_a_reg <= sin_a_next;
        sin_b_reg <= sin_b_next;
    end

    assign line_a_out = a_out_reg;
    assign line_b_out = b_out_reg;
    assign line_a_oe = {3{line_oe_reg}};
    assign line_b_oe = {3{line_oe_reg}};
    assign hs_status_a = hs_a_reg;
    assign hs_status_b = hs_b_reg;
    assign serial_in_a = sin_a_reg;
    assign serial_in_b = sin_b_reg;

    // ----------------------------------------------------------------
    // straps
    // ----------------------------------------------------------------
    strap_s strap_sample;

    always_comb begin
        strap_sample.cfg_port_select_strap = line_a_s.rts_n;
        strap_sample.default_clear_strap_n = line_a_s.dtr_n;
        strap_sample.rom_enable_strap_n = line_a_s.sout;
        strap_sample.clk48_enable_bit = line_b_s.sout;
    end

    strap_latch u_strap_latch (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .strap_sample(strap_sample),
        .sw_wr_24(sw_wr_24),
        .sw_data_24(sw_data_24),
        .sw_wr_26(sw_wr_26),
        .sw_data_26(sw_data_26),
        .straps(straps)
    );

    assign cfg_port_addr = straps.cfg_port_select_strap ? CFG_PORT_HIGH : CFG_PORT_LOW;

endmodule

// [pin_mux_pkg.sv]
// shared types and constants for the port pin steering block
package pin_mux_pkg;

    // ----------------------------------------------------------------
    // pin groups and modes
    // ----------------------------------------------------------------
    localparam int PD_LOW_BIT = 3;
    localparam int PD_HIGH_BIT = 7;
    localparam int PD_WIDTH = PD_HIGH_BIT - PD_LOW_BIT + 1;
    localparam int PD_IDX_READ = 3 - PD_LOW_BIT;
    localparam int PD_IDX_CHANGE = 4 - PD_LOW_BIT;
    localparam int PD_IDX_FLOAT = 5 - PD_LOW_BIT;
    localparam int PD_IDX_MOTOR = 6 - PD_LOW_BIT;
    localparam int PD_IDX_SELECT = 7 - PD_LOW_BIT;

    typedef enum logic [1:0] {
        MODE_PRINTER,
        MODE_EXT_SINGLE,
        MODE_EXT_DUAL
    } pin_mode_e;

    // ----------------------------------------------------------------
    // configuration bit positions and values
    // ----------------------------------------------------------------
    localparam int REG24_CLEAR_BIT = 0;
    localparam int REG24_ROM_BIT = 1;
    localparam int REG24_CLK48_BIT = 6;
    localparam int REG26_PORT_BIT = 6;
    localparam logic [7:0] CFG_PORT_HIGH = 8'h4E;
    localparam logic [7:0] CFG_PORT_LOW = 8'h2E;

    // ----------------------------------------------------------------
    // handshake status bit positions
    // ----------------------------------------------------------------
    localparam int HS_CTS_BIT = 4;
    localparam int HS_DSR_BIT = 5;
    localparam int HS_RI_BIT = 6;
    localparam int HS_DCD_BIT = 7;
    localparam logic [7:0] HS_RESET = 8'h00;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic cts_n;
        logic dsr_n;
        logic dcd_n;
        logic ri_n;
        logic sin;
    } modem_in_s;

    typedef struct packed {
        logic rts_n;
        logic dtr_n;
        logic sout;
    } uart_line_s;

    typedef struct packed {
        logic cfg_port_select_strap;
        logic default_clear_strap_n;
        logic rom_enable_strap_n;
        logic clk48_enable_bit;
    } strap_s;

    localparam int SYNC_WIDTH = PD_WIDTH + 2 * $bits(modem_in_s) + 2 * $bits(uart_line_s);

endpackage

// [strap_latch.sv]
// strap capture during power-on reset with software overwrite
`timescale 1ns/1ps

module strap_latch
    import pin_mux_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire strap_s strap_sample,
    input wire logic sw_wr_24,
    input wire logic [7:0] sw_data_24,
    input wire logic sw_wr_26,
    input wire logic [7:0] sw_data_26,
    output strap_s straps
);

    strap_s straps_reg;
    strap_s straps_next;

    // ----------------------------------------------------------------
    // capture and hold
    // ----------------------------------------------------------------
    always_comb begin
        straps_next = straps_reg;
        if (!rst_n) begin
            straps_next = strap_sample;
        end else begin
            if (sw_wr_24) begin
                straps_next.default_clear_strap_n = sw_data_24[REG24_CLEAR_BIT];
                straps_next.rom_enable_strap_n = sw_data_24[REG24_ROM_BIT];
                straps_next.clk48_enable_bit = sw_data_24[REG24_CLK48_BIT];
            end
            if (sw_wr_26) begin
                straps_next.cfg_port_select_strap = sw_data_26[REG26_PORT_BIT];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        straps_reg <= straps_next;
    end

    assign straps = straps_reg;

endmodule

// [pin_mux_chk.sv]
// assertion checker for the port pin steering block
`timescale 1ns/1ps
module pin_mux_chk
    import pin_mux_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire pin_mode_e mode,
    input wire logic [PD_WIDTH-1:0] pp_data_out,
    input wire logic pp_data_oe,
    input wire logic floppy_motor_on_a_n,
    input wire logic floppy_select_a_n,
    input wire logic [PD_WIDTH-1:0] pd_pin_out,
    input wire logic [PD_WIDTH-1:0] pd_pin_oe,
    input wire modem_in_s modem_a_in,
    input wire uart_line_s uart_a_ctl,
    input wire uart_line_s line_a_in,
    input wire uart_line_s line_a_out,
    input wire uart_line_s line_a_oe,
    input wire logic [7:0] hs_status_a,
    input wire logic sw_wr_24,
    input wire logic sw_wr_26,
    input wire strap_s straps,
    input wire logic [7:0] cfg_port_addr
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    chk_printer_pins: assert property ($past(rst_n) && $past(mode) == MODE_PRINTER
        |-> pd_pin_out == $past(pp_data_out) && pd_pin_oe == {PD_WIDTH{$past(pp_data_oe)}})
        else $error("printer pins wrong");
    chk_single_float: assert property ($past(rst_n) && $past(mode) == MODE_EXT_SINGLE
        |-> pd_pin_oe == '0) else $error("single mode pin driven");
    chk_motor_drive: assert property ($past(rst_n) && $past(mode) == MODE_EXT_DUAL
        |-> pd_pin_oe[PD_IDX_MOTOR] == !$past(floppy_motor_on_a_n) && !pd_pin_out[PD_IDX_MOTOR])
        else $error("motor pin wrong");
    chk_select_drive: assert property ($past(rst_n) && $past(mode) == MODE_EXT_DUAL
        |-> pd_pin_oe[PD_IDX_SELECT] == !$past(floppy_select_a_n) && !pd_pin_out[PD_IDX_SELECT])
        else $error("select pin wrong");
    chk_cts_status: assert property ($past(rst_n)
        |-> hs_status_a[HS_CTS_BIT] == !$past(modem_a_in.cts_n, 3)) else $error("cts bit wrong");
    chk_line_drive: assert property ($past(rst_n)
        |-> line_a_out == $past(uart_a_ctl) && line_a_oe == '1) else $error("line a wrong");
    chk_strap_capture: assert property ($rose(rst_n)
        |-> {straps[3:1]} == {$past(line_a_in, 3)}) else $error("strap capture wrong");
    chk_straps_held: assert property ($past(rst_n) && !$past(sw_wr_24) && !$past(sw_wr_26)
        |-> $stable(straps)) else $error("straps moved");
    chk_port_addr: assert property (cfg_port_addr ==
        (straps.cfg_port_select_strap ? CFG_PORT_HIGH : CFG_PORT_LOW)) else $error("port wrong");
endmodule
bind port_pin_mux_strap_capture pin_mux_chk pin_mux_chk_inst (.clk_sys, .rst_n, .mode,
    .pp_data_out, .pp_data_oe, .floppy_motor_on_a_n, .floppy_select_a_n, .pd_pin_out,
    .pd_pin_oe, .modem_a_in, .uart_a_ctl, .line_a_in, .line_a_out, .line_a_oe, .hs_status_a,
    .sw_wr_24, .sw_wr_26, .straps, .cfg_port_addr);

// [pin_partner.sv]
// far-side model of the parallel pins and serial strap pins
`timescale 1ns/1ps
module pin_partner
    import pin_mux_pkg::*;
(
    input wire logic [PD_WIDTH-1:0] pd_pin_out,
    input wire logic [PD_WIDTH-1:0] pd_pin_oe,
    input wire logic [PD_WIDTH-1:0] ext_val,
    input wire logic [PD_WIDTH-1:0] ext_en,
    output logic [PD_WIDTH-1:0] pd_pin_in,
    input wire uart_line_s line_a_out,
    input wire uart_line_s line_a_oe,
    input wire uart_line_s line_b_out,
    input wire uart_line_s line_b_oe,
    input wire uart_line_s strap_a,
    input wire uart_line_s strap_b,
    output uart_line_s line_a_in,
    output uart_line_s line_b_in
);
    // device wins, then drive or printer, else pull-up
    assign pd_pin_in = (pd_pin_oe & pd_pin_out) | (~pd_pin_oe & (ext_val | ~ext_en));
    // released strap pins sit at the resistor level
    assign line_a_in = (line_a_oe & line_a_out) | (~line_a_oe & strap_a);
    assign line_b_in = (line_b_oe & line_b_out) | (~line_b_oe & strap_b);
endmodule

// [test_port_pin_mux_strap_capture.sv]
// self-checking testbench for the port pin steering block
`timescale 1ns/1ps
module test_port_pin_mux_strap_capture;
    import pin_mux_pkg::*;
    logic clk_sys = 1'b0, rst_n = 1'b0, pp_data_oe = 1'b0, sw_wr_24 = 1'b0, sw_wr_26 = 1'b0;
    logic floppy_motor_on_a_n = 1'b1, floppy_select_a_n = 1'b1;
    logic ext_read_data_n, ext_disk_change_n, serial_in_a, serial_in_b;
    pin_mode_e mode = MODE_PRINTER;
    logic [PD_WIDTH-1:0] pp_data_out = '0, ext_val = '0, ext_en = '1;
    logic [PD_WIDTH-1:0] pp_data_in, pd_pin_in, pd_pin_out, pd_pin_oe;
    logic [7:0] sw_data_24 = '0, sw_data_26 = '0, hs_status_a, hs_status_b, cfg_port_addr;
    modem_in_s modem_a_in = '1, modem_b_in = '1;
    uart_line_s uart_a_ctl = '1, uart_b_ctl = '1, strap_a = '0, strap_b = '0;
    uart_line_s line_a_in, line_b_in, line_a_out, line_a_oe, line_b_out, line_b_oe;
    strap_s straps;
    int miscompares = 0, check_count = 0;
    port_pin_mux_strap_capture port_pin_mux_strap_capture_inst (.clk_sys, .rst_n, .mode,
        .pp_data_out, .pp_data_oe, .pp_data_in, .floppy_motor_on_a_n, .floppy_select_a_n,
        .ext_read_data_n, .ext_disk_change_n, .pd_pin_in, .pd_pin_out, .pd_pin_oe,
        .modem_a_in, .modem_b_in, .uart_a_ctl, .uart_b_ctl, .line_a_in, .line_b_in,
        .line_a_out, .line_a_oe, .line_b_out, .line_b_oe, .serial_in_a, .serial_in_b,
        .hs_status_a, .hs_status_b, .sw_wr_24, .sw_data_24, .sw_wr_26, .sw_data_26, .straps,
        .cfg_port_addr);
    pin_partner pin_partner_inst (.pd_pin_out, .pd_pin_oe, .ext_val, .ext_en, .pd_pin_in,
        .line_a_out, .line_a_oe, .line_b_out, .line_b_oe, .strap_a, .strap_b, .line_a_in,
        .line_b_in);
    task automatic check(string name, logic [9:0] exp, logic [9:0] got);
        check_count++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            miscompares++;
        end
    endtask
    function automatic logic [9:0] pins(pin_mode_e m, logic [4:0] d, logic oe, logic mo, logic ds);
        if (m == MODE_PRINTER) return {{PD_WIDTH{oe}}, d};
        if (m == MODE_EXT_DUAL) return {~ds, ~mo, 8'h00};
        return '0;
    endfunction
    function automatic logic [7:0] hs(modem_in_s x);
        return {~x.dcd_n, ~x.ri_n, ~x.dsr_n, ~x.cts_n, 4'h0};
    endfunction
    task automatic do_reset(uart_line_s sa, uart_line_s sb);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        strap_a <= sa;
        strap_b <= sb;
        repeat (6) @(posedge clk_sys);
        #1;
        check("line_a_oe", 0, line_a_oe);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        #1;
        check("straps", {sa.rts_n, sa.dtr_n, sa.sout, sb.sout}, straps);
        check("port", sa.rts_n ? CFG_PORT_HIGH : CFG_PORT_LOW, cfg_port_addr);
        $display("test reset done");
    endtask
    task automatic sw_write(logic [7:0] v24, logic [7:0] v26);
        @(posedge clk_sys);
        {sw_wr_24, sw_wr_26, sw_data_24, sw_data_26} <= {2'b11, v24, v26};
        @(posedge clk_sys);
        {sw_wr_24, sw_wr_26} <= 2'b00;
        repeat (4) @(posedge clk_sys);
        #1;
        check("straps", {v26[6], v24[0], v24[1], v24[6]}, straps);
        check("port", v26[6] ? CFG_PORT_HIGH : CFG_PORT_LOW, cfg_port_addr);
    endtask
    task automatic conclude();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial forever #4 clk_sys = ~clk_sys;
    initial begin
        #20000;
        miscompares++;
        conclude();
    end
    initial begin
        logic [9:0] e;
        logic [4:0] lvl;
        void'($urandom(14981));
        do_reset('1, '1);
        do_reset('0, '0);
        for (int i = 0; i < 60; i++) begin
            @(posedge clk_sys);
            mode <= pin_mode_e'($urandom_range(2));
            {pp_data_out, pp_data_oe, floppy_motor_on_a_n, floppy_select_a_n} <= 8'($urandom);
            {ext_val, ext_en} <= 10'($urandom);
            {modem_a_in, modem_b_in} <= 10'($urandom);
            {uart_a_ctl, uart_b_ctl} <= 6'($urandom);
            repeat (4) @(posedge clk_sys);
            #1;
            e = pins(mode, pp_data_out, pp_data_oe, floppy_motor_on_a_n, floppy_select_a_n);
            check("pd_pin", e, {pd_pin_oe, pd_pin_out});
            lvl = (e[9:5] & e[4:0]) | (~e[9:5] & (ext_val | ~ext_en));
            if (mode == MODE_PRINTER)
                check("pp_data_in", lvl, pp_data_in);
            else
                check("ext_in", lvl[1:0], {ext_disk_change_n, ext_read_data_n});
            check("hs", {hs(modem_a_in), 2'b0}, {hs_status_a, 2'b0});
            check("hs_b", hs(modem_b_in), hs_status_b);
            check("line", {uart_a_ctl, uart_b_ctl}, {line_a_out, line_b_out});
            check("line_oe", 6'h3F, {line_a_oe, line_b_oe});
            check("sin", {modem_a_in.sin, modem_b_in.sin}, {serial_in_a, serial_in_b});
        end
        check("straps", 0, straps);
        $display("test pin steering done");
        sw_write(8'h41, 8'h40);
        sw_write(8'h00, 8'h00);
        for (int i = 0; i < 8; i++) sw_write(8'($urandom), 8'($urandom));
        $display("test software write done");
        do_reset('1, '0);
        conclude();
    end
endmodule
